// ### common/wayside_msg_pkg.sv
package wayside_msg_pkg;

  localparam int MSG_BITS = 19;
  localparam int FIELD_W = 5;

  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DIVIDER = 8'h08;
  localparam logic [7:0] OFS_LAST_MSG = 8'h0c;
  localparam logic [7:0] OFS_MAP_BASE = 8'h40;
  localparam int MAP_ENTRIES = 32;

  // control fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_LIGHT_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // bit period in clock cycles, wayside needs four messages per pass
  localparam logic [15:0] DIVIDER_RESET = 16'h0032;
  localparam logic [15:0] LIGHT_HOLD_RESET = 16'hffff;

  // source selection for each message bit
  localparam logic [4:0] SRC_ZERO = 5'h00;
  localparam logic [4:0] SRC_ONE = 5'h01;
  localparam logic [4:0] SRC_ROLE_ACTIVE = 5'h02;
  localparam logic [4:0] SRC_END_TRAIN = 5'h03;
  localparam logic [4:0] SRC_CANCEL = 5'h04;
  localparam logic [4:0] SRC_SW_LEFT = 5'h05;
  localparam logic [4:0] SRC_SW_RIGHT = 5'h06;
  localparam logic [4:0] SRC_PREEMPT = 5'h07;
  localparam logic [4:0] SRC_NUM_BASE = 5'h08;
  localparam logic [4:0] SRC_NUM_LAST = 5'h15;

  typedef enum logic [1:0] {
    ROLE_SILENT = 2'b00,
    ROLE_LEAD = 2'b01,
    ROLE_TRAIL = 2'b11
  } role_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SHIFT = 2'b01,
    TX_DONE = 2'b11
  } tx_state_t;

  typedef struct packed {
    logic cab_active;
    logic trailing_cab;
    logic end_of_train;
    logic preempt;
    logic switch_left;
    logic switch_right;
    logic cancel;
    logic [3:0] route_tens;
    logic [3:0] route_units;
    logic [3:0] train_tens;
    logic [3:0] train_units;
    logic [11:0] vehicle_jumper;
    logic interrogate;
  } panel_in_t;

  localparam int PANEL_W = $bits(panel_in_t);

endpackage : wayside_msg_pkg

// ### design/pin_sync.sv
module pin_sync
  import wayside_msg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [PANEL_W-1:0] async_in,
  output logic [PANEL_W-1:0] sync_out
);

  typedef struct packed {
    logic [PANEL_W-1:0] first;
    logic [PANEL_W-1:0] second;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  always_comb begin
    st_nxt.first = async_in;
    st_nxt.second = st_r.first;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.second;

endmodule : pin_sync

// ### design/wayside_transponder_message.sv
// Operation
// - every answer is exactly 19 message bits long
// - interrogation detected starts serial transmission of the message
// - bit rate high enough for four full messages per pass
// - trailing cab always answers; non-lead, non-trailing stays silent
// - energized leading cab answers with its own content
// - lead message: active flag, train 0-99, route 0-99, call flags
// - trailing message: inactive flag, end-of-train, vehicle 0-999
// - message content comes only from the cab panel; the software map can also select constant 0 or 1 bits
// - backlights lit while the active cab is interrogated
// - four pushbuttons feed preempt, left, right and cancel flags
// - four thumbwheel digits give route code and train number
// - vehicle number comes from fixed jumper setting
// - cab active, trailing and end-of-train choose role and content
//
// The placing of the registers and the APB register port are this design's own decisions.
module wayside_transponder_message
  import wayside_msg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic interrogate_in,
  input wire logic cab_active_in,
  input wire logic trailing_cab_in,
  input wire logic end_of_train_in,
  input wire logic preempt_btn,
  input wire logic switch_left_btn,
  input wire logic switch_right_btn,
  input wire logic cancel_btn,
  input wire logic [3:0] route_tens_in,
  input wire logic [3:0] route_units_in,
  input wire logic [3:0] train_tens_in,
  input wire logic [3:0] train_units_in,
  input wire logic [11:0] vehicle_jumper_in,
  output logic tx_data,
  output logic tx_active,
  output logic backlight
);

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] ctrl;
    logic [15:0] divider;
    logic [MAP_ENTRIES*FIELD_W-1:0] map_lead;
    logic [MAP_ENTRIES*FIELD_W-1:0] map_trail;
    tx_state_t tx_state;
    role_t role;
    logic [MSG_BITS-1:0] shreg;
    logic [MSG_BITS-1:0] last_msg;
    logic [4:0] bit_cnt;
    logic [15:0] baud_cnt;
    logic interrogate_d;
    logic [15:0] msg_count;
    logic tx_data;
    logic tx_active;
    logic backlight;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  panel_in_t pin;
  logic [PANEL_W-1:0] pin_flat;
  logic [MSG_BITS-1:0] msg_built;
  role_t role_now;

  // all panel and car discretes come from outside the clock domain
  pin_sync u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .async_in({cab_active_in, trailing_cab_in, end_of_train_in,
               preempt_btn, switch_left_btn, switch_right_btn, cancel_btn,
               route_tens_in, route_units_in, train_tens_in, train_units_in,
               vehicle_jumper_in, interrogate_in}),
    .sync_out(pin_flat)
  );
  assign pin = panel_in_t'(pin_flat);

  // default layout: lead gets flag, buttons, 7-bit route, 7-bit train
  function automatic logic [MAP_ENTRIES*FIELD_W-1:0] default_map(
    input logic lead
  );
    logic [MAP_ENTRIES*FIELD_W-1:0] m;
    m = '0;
    for (int i = 0; i < MSG_BITS; i++) begin
      if (i == 0) begin
        m[i*FIELD_W +: FIELD_W] = SRC_ROLE_ACTIVE;
      end else if (lead && i < 5) begin
        m[i*FIELD_W +: FIELD_W] = 5'(int'(SRC_CANCEL) + i - 1);
      end else if (!lead && i == 1) begin
        m[i*FIELD_W +: FIELD_W] = SRC_END_TRAIN;
      end else if (lead) begin
        m[i*FIELD_W +: FIELD_W] = 5'(int'(SRC_NUM_BASE) + i - 5);
      end else begin
        m[i*FIELD_W +: FIELD_W] = 5'(int'(SRC_NUM_BASE) + i - 2);
      end
    end
    return m;
  endfunction : default_map

  // reset contents of the source maps
  localparam logic [MAP_ENTRIES*FIELD_W-1:0] MAP_LEAD_RESET =
    default_map(1'b1);
  localparam logic [MAP_ENTRIES*FIELD_W-1:0] MAP_TRAIL_RESET =
    default_map(1'b0);

  // two bcd digits to binary
  function automatic logic [9:0] bcd2(input logic [3:0] t,
                                      input logic [3:0] u);
    return 10'(t) * 10'd10 + 10'(u);
  endfunction : bcd2

  // numeric payload: lead packs route then train, trail the vehicle
  // two digits give at most 99, so 7 bits per number fill the lead message
  function automatic logic [13:0] number_field(input panel_in_t p,
                                               input logic lead);
    logic [9:0] route;
    logic [9:0] train;
    route = bcd2(p.route_tens, p.route_units);
    train = bcd2(p.train_tens, p.train_units);
    if (lead) begin
      return {train[6:0], route[6:0]};
    end
    return {2'b00, p.vehicle_jumper};
  endfunction : number_field

  function automatic logic pick_bit(input logic [4:0] src,
                                    input panel_in_t p,
                                    input logic lead);
    logic [13:0] num;
    num = number_field(p, lead);
    case (src)
      SRC_ZERO: return 1'b0;
      SRC_ONE: return 1'b1;
      SRC_ROLE_ACTIVE: return lead;
      SRC_END_TRAIN: return p.end_of_train;
      SRC_CANCEL: return p.cancel;
      SRC_SW_LEFT: return p.switch_left;
      SRC_SW_RIGHT: return p.switch_right;
      SRC_PREEMPT: return p.preempt;
      default: begin
        if (src >= SRC_NUM_BASE && src <= SRC_NUM_LAST) begin
          return num[4'(src - SRC_NUM_BASE)];
        end
        return 1'b0;
      end
    endcase
  endfunction : pick_bit

  always_comb begin
    if (pin.trailing_cab) begin
      role_now = ROLE_TRAIL;
    end else if (pin.cab_active) begin
      role_now = ROLE_LEAD;
    end else begin
      role_now = ROLE_SILENT;
    end
  end

  // message assembled through the map from panel inputs or constant 0 and 1 sources
  always_comb begin
    msg_built = '0;
    for (int i = 0; i < MSG_BITS; i++) begin
      if (role_now == ROLE_LEAD) begin
        msg_built[i] = pick_bit(st_r.map_lead[i*FIELD_W +: FIELD_W],
                                pin, 1'b1);
      end else begin
        msg_built[i] = pick_bit(st_r.map_trail[i*FIELD_W +: FIELD_W],
                                pin, 1'b0);
      end
    end
  end

  always_comb begin
    logic access;
    logic [5:0] idx;
    access = psel && penable && !st_r.pready;
    idx = 6'(paddr[7:2] - OFS_MAP_BASE[7:2]);
    st_nxt = st_r;
    st_nxt.pready = access;
    st_nxt.pslverr = 1'b0;
    st_nxt.interrogate_d = pin.interrogate;

    if (access) begin
      st_nxt.prdata = '0;
      if (paddr[1:0] != 2'b00) begin
        st_nxt.pslverr = 1'b1;
      end else if (paddr >= OFS_MAP_BASE) begin
        if (idx < 6'(MAP_ENTRIES)) begin
          if (pwrite) begin
            st_nxt.map_lead[5'(idx)*FIELD_W +: FIELD_W] = pwdata[4:0];
            st_nxt.map_trail[5'(idx)*FIELD_W +: FIELD_W] = pwdata[12:8];
          end
          st_nxt.prdata = {19'h0, st_r.map_trail[5'(idx)*FIELD_W +: FIELD_W],
                           3'h0, st_r.map_lead[5'(idx)*FIELD_W +: FIELD_W]};
        end else begin
          st_nxt.pslverr = 1'b1;
        end
      end else begin
        case (paddr)
          OFS_CTRL: begin
            if (pwrite) begin
              st_nxt.ctrl = {30'h0, pwdata[1:0]};
            end
            st_nxt.prdata = st_r.ctrl;
          end
          OFS_STATUS: begin
            st_nxt.prdata = {st_r.msg_count, 8'h0, 1'b0, st_r.backlight,
                             st_r.tx_active, pin.interrogate, 2'h0,
                             st_r.role};
          end
          OFS_DIVIDER: begin
            if (pwrite && pwdata[15:0] != 16'h0000) begin
              st_nxt.divider = pwdata[15:0];
            end
            st_nxt.prdata = {16'h0, st_r.divider};
          end
          OFS_LAST_MSG: begin
            st_nxt.prdata = {13'h0, st_r.last_msg};
          end
          default: begin
            st_nxt.pslverr = 1'b1;
          end
        endcase
      end
    end

    case (st_r.tx_state)
      TX_IDLE: begin
        st_nxt.tx_active = 1'b0;
        st_nxt.tx_data = 1'b0;
        if (pin.interrogate && !st_r.interrogate_d &&
            st_r.ctrl[CTRL_ENABLE_BIT] && role_now != ROLE_SILENT) begin
          st_nxt.shreg = msg_built;
          st_nxt.last_msg = msg_built;
          st_nxt.role = role_now;
          st_nxt.bit_cnt = 5'(MSG_BITS);
          st_nxt.baud_cnt = st_r.divider;
          st_nxt.tx_state = TX_SHIFT;
          st_nxt.tx_active = 1'b1;
          st_nxt.tx_data = msg_built[0];
        end
      end
      TX_SHIFT: begin
        if (st_r.baud_cnt > 16'h0001) begin
          st_nxt.baud_cnt = st_r.baud_cnt - 16'h0001;
        end else if (st_r.bit_cnt > 5'h01) begin
          st_nxt.shreg = st_r.shreg >> 1;
          st_nxt.tx_data = st_r.shreg[1];
          st_nxt.bit_cnt = st_r.bit_cnt - 5'h01;
          st_nxt.baud_cnt = st_r.divider;
        end else begin
          st_nxt.tx_state = TX_DONE;
          st_nxt.tx_active = 1'b0;
          st_nxt.tx_data = 1'b0;
          st_nxt.msg_count = st_r.msg_count + 16'h0001;
        end
      end
      TX_DONE: begin
        st_nxt.tx_state = TX_IDLE;
      end
      default: begin
        st_nxt.tx_state = TX_IDLE;
      end
    endcase

    // repeated interrogation while the car sits over the loop
    if (st_r.tx_state == TX_DONE && pin.interrogate) begin
      st_nxt.interrogate_d = 1'b0;
    end

    st_nxt.backlight = (pin.interrogate && role_now == ROLE_LEAD) ||
                       st_r.ctrl[CTRL_LIGHT_BIT];
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
      st_r.ctrl <= CTRL_RESET;
      st_r.divider <= DIVIDER_RESET;
      st_r.map_lead <= MAP_LEAD_RESET;
      st_r.map_trail <= MAP_TRAIL_RESET;
      st_r.tx_state <= TX_IDLE;
      st_r.role <= ROLE_SILENT;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign tx_data = st_r.tx_data;
  assign tx_active = st_r.tx_active;
  assign backlight = st_r.backlight;

endmodule : wayside_transponder_message

// ### verif/wayside_msg_properties.sv
module wayside_msg_checker
  import wayside_msg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic interrogate_in,
  input wire logic cab_active_in,
  input wire logic trailing_cab_in,
  input wire logic tx_data,
  input wire logic tx_active
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] div_r;
  logic [31:0] len_r;
  logic [31:0] ph_r;
  logic bad;
  // bit period follows software writes
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= DIVIDER_RESET;
      len_r <= '0;
      ph_r <= '0;
    end else begin
      if (psel && penable && pready && pwrite && paddr == OFS_DIVIDER
          && pwdata[15:0] != 16'h0000) begin
        div_r <= pwdata[15:0];
      end
      len_r <= tx_active ? len_r + 1 : '0;
      ph_r <= (!tx_active || ph_r == 32'(div_r) - 1) ? '0 : ph_r + 1;
    end
  end
  assign bad = paddr[1:0] != 2'b00 || paddr > 8'hbc
    || (paddr > OFS_LAST_MSG && paddr < OFS_MAP_BASE);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_end;
    $fell(tx_active);
  endsequence
  sequence s_gap;
    !tx_active [*2];
  endsequence
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("no ready after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_addr: assert property (pready |-> pslverr == bad)
    else $error("error response wrong");
  a_err_data: assert property (pslverr |-> prdata == 32'h0)
    else $error("data on error response");
  a_msg_length: assert property (
    s_end |-> len_r == MSG_BITS * div_r)
    else $error("message length wrong");
  a_bit_hold: assert property (
    tx_active && ph_r != 0 |-> $stable(tx_data))
    else $error("bit changed inside period");
  a_idle_low: assert property (!tx_active |-> !tx_data)
    else $error("data while idle");
  a_msg_gap: assert property (s_end |-> s_gap)
    else $error("no idle gap");
  a_tx_cause: assert property (
    $rose(tx_active) |-> $past(interrogate_in, 3)
      && ($past(cab_active_in, 3) || $past(trailing_cab_in, 3)))
    else $error("answer without cause");
endmodule : wayside_msg_checker

bind wayside_transponder_message wayside_msg_checker chk_i (
  .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .interrogate_in(interrogate_in),
  .cab_active_in(cab_active_in), .trailing_cab_in(trailing_cab_in),
  .tx_data(tx_data), .tx_active(tx_active)
);

// ### verif/wayside_loop_model.sv
module wayside_loop_model
  import wayside_msg_pkg::*;
#(parameter int DIV = 8)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic req,
  input wire logic tx_data,
  input wire logic tx_active,
  output logic interrogate_in,
  output logic [18:0] rx_msg,
  output int rx_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  int ph;
  int n;
  logic [18:0] sh;
  assign interrogate_in = req;
  // samples mid-bit, first bit is bit 0
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      n = 0;
      ph = 0;
      rx_cnt <= 0;
      rx_msg <= '0;
    end else if (tx_active) begin
      if (ph == DIV / 2 && n < MSG_BITS) begin
        sh[n] = tx_data;
        n++;
      end
      ph = (ph == DIV - 1) ? 0 : ph + 1;
    end else begin
      if (n == MSG_BITS) begin
        rx_msg <= sh;
        rx_cnt <= rx_cnt + 1;
      end
      n = 0;
      ph = 0;
    end
  end
endmodule : wayside_loop_model

// ### verif/testbench.sv
module testbench;
  import wayside_msg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, e, tx_data, tx_active, backlight, interrogate_in;
  logic req = 0, cab_active_in = 0, trailing_cab_in = 0;
  logic end_of_train_in = 0, preempt_btn = 0, switch_left_btn = 0;
  logic switch_right_btn = 0, cancel_btn = 0;
  logic [3:0] route_tens_in = 4'h7, route_units_in = 4'h3;
  logic [3:0] train_tens_in = 4'h4, train_units_in = 4'h2;
  logic [11:0] vehicle_jumper_in = 12'h3e7;
  logic [18:0] rx_msg;
  int rx_cnt, num_errors = 0, checks_done = 0;
  wayside_transponder_message dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .interrogate_in(interrogate_in),
    .cab_active_in(cab_active_in), .trailing_cab_in(trailing_cab_in),
    .end_of_train_in(end_of_train_in), .preempt_btn(preempt_btn),
    .switch_left_btn(switch_left_btn),
    .switch_right_btn(switch_right_btn), .cancel_btn(cancel_btn),
    .route_tens_in(route_tens_in), .route_units_in(route_units_in),
    .train_tens_in(train_tens_in), .train_units_in(train_units_in),
    .vehicle_jumper_in(vehicle_jumper_in), .tx_data(tx_data),
    .tx_active(tx_active), .backlight(backlight)
  );
  wayside_loop_model #(.DIV(8)) partner (
    .sys_clk(sys_clk), .rst_b(rst_b), .req(req), .tx_data(tx_data),
    .tx_active(tx_active), .interrogate_in(interrogate_in),
    .rx_msg(rx_msg), .rx_cnt(rx_cnt)
  );
  always #25 sys_clk = ~sys_clk;
  task end_sim;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, s, x);
    end
  endtask : chk
  task tmo(input int i);
    if (i >= 500) begin
      num_errors++;
      $display("CHECK FAILED %0t wait ran out", $time);
      end_sim;
    end
  endtask : tmo
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (pready !== 1'b1 && i < 500);
    tmo(i);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask : apb
  task rdc(input logic [7:0] a, input logic [31:0] x);
    apb(0, a, 0);
    chk(q, x);
  endtask : rdc
  task wait_tx(input logic v);
    int i;
    i = 0;
    while (tx_active !== v && i < 500) begin
      @(posedge sys_clk);
      i++;
    end
    tmo(i);
  endtask : wait_tx
  task msg(input logic bl, input logic [18:0] x, input logic [18:0] m);
    int c, i;
    c = rx_cnt;
    req <= 1;
    wait_tx(1);
    chk(32'(backlight), 32'(bl));
    i = 0;
    while (rx_cnt == c && i < 500) begin
      @(posedge sys_clk);
      i++;
    end
    tmo(i);
    chk(32'(rx_msg & m), 32'(x & m));
    req <= 0;
    repeat (8) @(posedge sys_clk);
    wait_tx(0);
    // let the partner count the repeated message before the next call
    repeat (2) @(posedge sys_clk);
  endtask : msg
  task quiet(input logic bl);
    int c;
    c = rx_cnt;
    req <= 1;
    repeat (60) @(posedge sys_clk);
    chk(32'(tx_active), 32'h0);
    chk(32'(rx_cnt - c), 32'h0);
    chk(32'(backlight), 32'(bl));
    req <= 0;
    repeat (8) @(posedge sys_clk);
  endtask : quiet
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1;
    @(posedge sys_clk);
    rdc(OFS_CTRL, CTRL_RESET);
    rdc(OFS_DIVIDER, 32'(DIVIDER_RESET));
    apb(0, 8'h10, 0);
    chk(32'(e), 32'h1);
    chk(q, 32'h0);
    apb(0, 8'h06, 0);
    chk(32'(e), 32'h1);
    apb(1, OFS_DIVIDER, 32'h8);
    apb(1, OFS_DIVIDER, 32'h0);
    rdc(OFS_DIVIDER, 32'h8);
    $display("test registers done");
    trailing_cab_in <= 1;
    end_of_train_in <= 1;
    msg(0, {5'h00, 12'h3e7, 2'b10}, '1);
    rdc(OFS_LAST_MSG, {13'h0, 5'h00, 12'h3e7, 2'b10});
    apb(0, OFS_STATUS, 0);
    chk(32'(q[1:0]), 32'(ROLE_TRAIL));
    chk(32'(q[31:16]), 32'h2);
    apb(1, OFS_MAP_BASE, {19'h0, SRC_ONE, 3'h0, SRC_ROLE_ACTIVE});
    end_of_train_in <= 0;
    msg(0, {5'h00, 12'h3e7, 2'b01}, '1);
    $display("test trailing done");
    trailing_cab_in <= 0;
    cab_active_in <= 1;
    cancel_btn <= 1;
    switch_right_btn <= 1;
    preempt_btn <= 1;
    msg(1, 19'h2a93b, '1);
    cancel_btn <= 0;
    switch_right_btn <= 0;
    preempt_btn <= 0;
    switch_left_btn <= 1;
    msg(1, 19'h2a925, '1);
    $display("test leading done");
    cab_active_in <= 0;
    quiet(0);
    trailing_cab_in <= 1;
    apb(1, OFS_CTRL, 32'h2);
    quiet(1);
    $display("test silent done");
    end_sim;
  end
endmodule : testbench
